// *** hw/rts_pkg.sv ***
// Shared constants and types of the transmitter sequencer and its controller.
// Assumes one 40 MHz system clock; each clk cycle models one crystal cycle.
package rts_pkg;
	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int LOCK_TIME_US = 3000;
	// Longest time, rounds down; the part locks one cycle inside it
	localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
	localparam int DEV_LOCK_CYCLES = LOCK_CYCLES - 1;
	localparam int WAIT_TIME_US = 3000;
	// Least time; whole microseconds keep the product inside 32 bits
	localparam int WAIT_CYCLES = WAIT_TIME_US * CLK_MHZ;
	localparam int MAX_BAUD = 32_000;
	localparam int SYMBOL_CYCLES = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;
	localparam int CNT_W = 17;
	localparam int SYM_W = 11;
	// --------------------------------------------------------------
	// Clock output and synthesizer
	// --------------------------------------------------------------
	localparam int DIV_W = 2;
	localparam int DIV_MSB = 1;
	localparam int VCO_SHIFT = 5;
	localparam int REF_W = 16;
	localparam int RF_W = REF_W + VCO_SHIFT;
	localparam logic [REF_W-1:0] REF_NOMINAL = 16'h2000;
	localparam logic [REF_W-1:0] REF_PULL = 16'h0010;
	localparam logic [RF_W-1:0] RF_OFF = 21'h000000;
	// --------------------------------------------------------------
	// States
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		RTS_STANDBY = 3'b001,
		RTS_LOCKING = 3'b010,
		RTS_LOCKED = 3'b100
	} rts_dev_state_e;
	typedef enum logic [5:0] {
		RTS_H_IDLE = 6'b000001,
		RTS_H_WARM = 6'b000010,
		RTS_H_PA_UP = 6'b000100,
		RTS_H_KEY = 6'b001000,
		RTS_H_PA_DOWN = 6'b010000,
		RTS_H_CLK_BACK = 6'b100000
	} rts_host_state_e;

	// VCO runs at 32 times the reference
	function automatic logic [RF_W-1:0] rts_vco_word(
		input logic [REF_W-1:0] ref_code);
		return {ref_code, 5'h00};
	endfunction : rts_vco_word
endpackage : rts_pkg

// *** hw/rts_link_if.sv ***
// Pins between the transmitter and its controller.
// The capacitor switch is open drain; the line idles high when released.
`timescale 1ns/100ps
`default_nettype none
interface rts_link_if;
	logic chip_en;
	logic amplifier_on;
	logic cap_sw_out;
	logic cap_sw_oe;
	logic clk_out;
	wire logic cap_line;

	// Released drain reads high; a driven drain pulls the capacitor to ground
	assign cap_line = cap_sw_oe ? cap_sw_out : 1'b1;

	modport dev (
		input chip_en,
		input amplifier_on,
		input cap_line,
		output clk_out
	);
	modport host (
		output chip_en,
		output amplifier_on,
		output cap_sw_out,
		output cap_sw_oe,
		input clk_out,
		input cap_line
	);
endinterface : rts_link_if
`default_nettype wire

// *** hw/rts_dev.sv ***
// Transmitter end: mode control, clock output and synthesizer model.
// Assumes the controller drives chip_en and amplifier_on synchronously.
`timescale 1ns/100ps
`default_nettype none
module rts_dev
	import rts_pkg::*;
#(
	parameter int LOCK_CYC = DEV_LOCK_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	rts_link_if.dev link,
	output logic [2:0] mode_ff,
	output logic osc_on_ff,
	output logic locked_ff,
	output logic amp_on_ff,
	output logic [RF_W-1:0] rf_freq_ff,
	output logic early_key_ff,
	output logic fast_key_ff
);
	// --------------------------------------------------------------
	// Mode state machine
	// --------------------------------------------------------------
	rts_dev_state_e state_ff;
	rts_dev_state_e nxt_state;
	logic [CNT_W-1:0] lock_cnt_ff;
	logic [CNT_W-1:0] nxt_lock_cnt;

	always_comb begin
		nxt_state = state_ff;
		nxt_lock_cnt = lock_cnt_ff;
		case (state_ff)
			RTS_STANDBY: begin
				nxt_lock_cnt = '0;
				if (link.chip_en) begin
					nxt_state = RTS_LOCKING;
				end
			end
			RTS_LOCKING: begin
				if (!link.chip_en) begin
					nxt_state = RTS_STANDBY;
				end else if (lock_cnt_ff == CNT_W'(LOCK_CYC - 1)) begin
					nxt_state = RTS_LOCKED;
				end else begin
					nxt_lock_cnt = lock_cnt_ff + 1'b1;
				end
			end
			RTS_LOCKED: begin
				if (!link.chip_en) begin
					nxt_state = RTS_STANDBY;
				end
			end
			default: begin
				nxt_state = RTS_STANDBY;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= RTS_STANDBY;
			lock_cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			lock_cnt_ff <= nxt_lock_cnt;
		end
	end

	// --------------------------------------------------------------
	// Crystal clock divider
	// --------------------------------------------------------------
	// Divider stops with the oscillator so the output parks low in standby
	logic [DIV_W-1:0] div_ff;
	logic [DIV_W-1:0] nxt_div;
	logic clk_out_ff;
	logic nxt_clk_out;

	always_comb begin
		nxt_div = '0;
		if (nxt_state != RTS_STANDBY) begin
			nxt_div = div_ff + 1'b1;
		end
		nxt_clk_out = nxt_div[DIV_MSB];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			div_ff <= '0;
			clk_out_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			clk_out_ff <= nxt_clk_out;
		end
	end

	assign link.clk_out = clk_out_ff;

	// --------------------------------------------------------------
	// Amplifier and synthesizer output
	// --------------------------------------------------------------
	logic nxt_osc_on;
	logic nxt_locked;
	logic nxt_amp_on;
	logic [REF_W-1:0] ref_code;
	logic [RF_W-1:0] nxt_rf_freq;

	always_comb begin
		nxt_osc_on = (nxt_state != RTS_STANDBY);
		nxt_locked = (nxt_state == RTS_LOCKED);
		// Amplifier is not held off while locking; keying early is legal
		// but radiates off frequency, so it is flagged below
		nxt_amp_on = link.chip_en && link.amplifier_on;
		// Load capacitor to ground pulls the crystal down
		ref_code = link.cap_line ? REF_NOMINAL
			: REF_NOMINAL - REF_PULL;
		nxt_rf_freq = RF_OFF;
		if (nxt_locked) begin
			nxt_rf_freq = rts_vco_word(ref_code);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mode_ff <= RTS_STANDBY;
			osc_on_ff <= 1'b0;
			locked_ff <= 1'b0;
			amp_on_ff <= 1'b0;
			rf_freq_ff <= RF_OFF;
		end else begin
			mode_ff <= nxt_state;
			osc_on_ff <= nxt_osc_on;
			locked_ff <= nxt_locked;
			amp_on_ff <= nxt_amp_on;
			rf_freq_ff <= nxt_rf_freq;
		end
	end

	// --------------------------------------------------------------
	// Keying watch
	// --------------------------------------------------------------
	// Flags are sticky per enable cycle and clear in standby, where a key
	// edge sets no flag, so a set never meets a clear
	logic amp_in_ff;
	logic cap_in_ff;
	logic [SYM_W-1:0] gap_ff;
	logic [SYM_W-1:0] nxt_gap;
	logic nxt_early;
	logic nxt_fast;
	logic key_edge;

	always_comb begin
		key_edge = (link.amplifier_on != amp_in_ff)
			|| (link.cap_line != cap_in_ff);
		nxt_gap = gap_ff;
		if (key_edge) begin
			nxt_gap = '0;
		end else if (gap_ff != SYM_W'(SYMBOL_CYCLES)) begin
			nxt_gap = gap_ff + 1'b1;
		end
		nxt_early = early_key_ff;
		nxt_fast = fast_key_ff;
		if (state_ff == RTS_STANDBY) begin
			nxt_early = 1'b0;
			nxt_fast = 1'b0;
			nxt_gap = SYM_W'(SYMBOL_CYCLES);
		end else begin
			if (state_ff == RTS_LOCKING && key_edge) begin
				nxt_early = 1'b1;
			end
			if (key_edge && gap_ff < SYM_W'(SYMBOL_CYCLES - 1)) begin
				nxt_fast = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			amp_in_ff <= 1'b0;
			cap_in_ff <= 1'b1;
			gap_ff <= SYM_W'(SYMBOL_CYCLES);
			early_key_ff <= 1'b0;
			fast_key_ff <= 1'b0;
		end else begin
			amp_in_ff <= link.amplifier_on;
			cap_in_ff <= link.cap_line;
			gap_ff <= nxt_gap;
			early_key_ff <= nxt_early;
			fast_key_ff <= nxt_fast;
		end
	end
endmodule : rts_dev
`default_nettype wire

// *** hw/rts_host.sv ***
// Controller end: enable sequencing and ASK or FSK keying of user bits.
// Assumes the user holds tx_bit valid until bit_take_ff shows that it was taken.
`timescale 1ns/100ps
`default_nettype none
module rts_host
	import rts_pkg::*;
#(
	parameter int WAIT_CYC = WAIT_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	rts_link_if.host link,
	input wire logic tx_start,
	input wire logic tx_fsk,
	input wire logic tx_bit,
	input wire logic tx_stop,
	output logic busy_ff,
	output logic bit_take_ff,
	output logic ext_clk_ff
);
	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	rts_host_state_e state_ff;
	rts_host_state_e nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic fsk_ff;
	logic nxt_fsk;
	logic stop_ff;
	logic nxt_stop;
	logic en_ff;
	logic nxt_en;
	logic amp_ff;
	logic nxt_amp;
	logic sw_ff;
	logic nxt_sw;
	logic nxt_take;
	logic nxt_ext;
	logic sym_end;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_fsk = fsk_ff;
		nxt_stop = stop_ff || tx_stop;
		nxt_en = en_ff;
		nxt_amp = amp_ff;
		nxt_sw = sw_ff;
		nxt_take = 1'b0;
		nxt_ext = ext_clk_ff;
		sym_end = (cnt_ff == '0);
		if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
		case (state_ff)
			RTS_H_IDLE: begin
				nxt_stop = 1'b0;
				nxt_en = 1'b0;
				nxt_amp = 1'b0;
				nxt_sw = 1'b0;
				if (tx_start) begin
					nxt_state = RTS_H_WARM;
					nxt_fsk = tx_fsk;
					nxt_en = 1'b1;
					nxt_cnt = CNT_W'(WAIT_CYC - 1);
				end
			end
			RTS_H_WARM: begin
				if (sym_end) begin
					nxt_ext = 1'b1;
					if (fsk_ff) begin
						nxt_state = RTS_H_PA_UP;
						nxt_amp = 1'b1;
						nxt_cnt = CNT_W'(SYMBOL_CYCLES - 1);
					end else begin
						nxt_state = RTS_H_KEY;
					end
				end
			end
			RTS_H_PA_UP: begin
				if (sym_end) begin
					nxt_state = RTS_H_KEY;
				end
			end
			RTS_H_KEY: begin
				if (sym_end) begin
					if (stop_ff) begin
						nxt_state = RTS_H_PA_DOWN;
						nxt_amp = 1'b0;
						nxt_sw = 1'b0;
					end else begin
						nxt_take = 1'b1;
						nxt_cnt = CNT_W'(SYMBOL_CYCLES - 1);
						if (fsk_ff) begin
							nxt_sw = tx_bit;
						end else begin
							nxt_amp = tx_bit;
						end
					end
				end
			end
			RTS_H_PA_DOWN: begin
				nxt_state = RTS_H_CLK_BACK;
				nxt_ext = 1'b0;
			end
			RTS_H_CLK_BACK: begin
				nxt_state = RTS_H_IDLE;
				nxt_en = 1'b0;
			end
			default: begin
				nxt_state = RTS_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= RTS_H_IDLE;
			cnt_ff <= '0;
			fsk_ff <= 1'b0;
			stop_ff <= 1'b0;
			en_ff <= 1'b0;
			amp_ff <= 1'b0;
			sw_ff <= 1'b0;
			bit_take_ff <= 1'b0;
			ext_clk_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			fsk_ff <= nxt_fsk;
			stop_ff <= nxt_stop;
			en_ff <= nxt_en;
			amp_ff <= nxt_amp;
			sw_ff <= nxt_sw;
			bit_take_ff <= nxt_take;
			ext_clk_ff <= nxt_ext;
			busy_ff <= (nxt_state != RTS_H_IDLE);
		end
	end

	// Open drain: only ever pulls low; bit 1 closes the switch
	assign link.chip_en = en_ff;
	assign link.amplifier_on = amp_ff;
	assign link.cap_sw_out = 1'b0;
	assign link.cap_sw_oe = sw_ff;
endmodule : rts_host
`default_nettype wire

// *** verif/rts_link_props.sv ***
// Checker of the link between controller and transmitter.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rts_link_props
	import rts_pkg::*;
#(
	parameter int WAIT_CYC = WAIT_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic chip_en,
	input wire logic amplifier_on,
	input wire logic cap_sw_out,
	input wire logic cap_sw_oe,
	input wire logic clk_out,
	input wire logic cap_line
);
	// ------------------------------
	// Helper counters
	// ------------------------------
	logic [CNT_W-1:0] en_cnt_ff;
	logic [CNT_W-1:0] nxt_en_cnt;
	logic [SYM_W-1:0] gap_ff;
	logic [SYM_W-1:0] nxt_gap;
	logic amp_q_ff;
	logic oe_q_ff;
	logic chg;

	assign chg = (amplifier_on != amp_q_ff) || (cap_sw_oe != oe_q_ff);
	// Standby sets the gap to its maximum, 11'h7FF, so a new transmission is not a fast key
	always_comb begin
		nxt_en_cnt = en_cnt_ff;
		if (!chip_en)
			nxt_en_cnt = '0;
		else if (en_cnt_ff != '1)
			nxt_en_cnt = en_cnt_ff + 1'b1;
		nxt_gap = gap_ff;
		if (chg)
			nxt_gap = 11'h001;
		else if (!chip_en)
			nxt_gap = 11'h7FF;
		else if (gap_ff != 11'h7FF)
			nxt_gap = gap_ff + 1'b1;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			en_cnt_ff <= '0;
			gap_ff <= 11'h7FF;
			amp_q_ff <= 1'b0;
			oe_q_ff <= 1'b0;
		end else begin
			en_cnt_ff <= nxt_en_cnt;
			gap_ff <= nxt_gap;
			amp_q_ff <= amplifier_on;
			oe_q_ff <= cap_sw_oe;
		end
	end
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_clk_div;
		$past(chip_en) && $past(chip_en, 2) |-> clk_out != $past(clk_out, 2);
	endproperty
	a_clk_div: assert property (p_clk_div)
		else $error("clock output not a quarter of crystal");
	property p_standby_clk;
		!$past(chip_en) |-> !clk_out;
	endproperty
	a_standby_clk: assert property (p_standby_clk)
		else $error("clock output runs in standby");
	property p_amp_wait;
		$rose(amplifier_on) |-> en_cnt_ff >= WAIT_CYC;
	endproperty
	a_amp_wait: assert property (p_amp_wait)
		else $error("amplifier keyed before the wait");
	property p_oe_wait;
		$rose(cap_sw_oe) |-> en_cnt_ff >= WAIT_CYC;
	endproperty
	a_oe_wait: assert property (p_oe_wait)
		else $error("switch keyed before the wait");
	property p_oe_after_amp;
		$rose(cap_sw_oe) |-> amplifier_on && $past(amplifier_on);
	endproperty
	a_oe_after_amp: assert property (p_oe_after_amp)
		else $error("switch keyed with amplifier off");
	property p_sym_gap;
		chg |-> gap_ff >= SYMBOL_CYCLES;
	endproperty
	a_sym_gap: assert property (p_sym_gap)
		else $error("keying faster than the symbol rate");
	property p_stop_order;
		$fell(chip_en) |-> !amplifier_on && !$past(amplifier_on) && !cap_sw_oe;
	endproperty
	a_stop_order: assert property (p_stop_order)
		else $error("enable dropped before amplifier");
	property p_amp_needs_en;
		amplifier_on |-> chip_en;
	endproperty
	a_amp_needs_en: assert property (p_amp_needs_en)
		else $error("amplifier on without enable");
	property p_start_idle;
		$rose(chip_en) |-> !amplifier_on && !cap_sw_oe;
	endproperty
	a_start_idle: assert property (p_start_idle)
		else $error("start with amplifier or switch active");
	property p_drain;
		cap_sw_oe |-> !cap_sw_out && !cap_line;
	endproperty
	a_drain: assert property (p_drain)
		else $error("switch drives the line high");
endmodule : rts_link_props
`default_nettype wire

// *** verif/tb_top.sv ***
// Bench: controller and transmitter joined, plus a loose transmitter
// keyed by hand. Assumes shortened lock and wait counts.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import rts_pkg::*;
	localparam int LK = 99;
	localparam int WT = 100;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic tx_start = 1'b0;
	logic tx_fsk = 1'b0;
	logic tx_bit = 1'b0;
	logic tx_stop = 1'b0;
	logic busy_ff, bit_take_ff, osc_on_ff, locked_ff, amp_on_ff, b, fsk;
	logic early_key_ff, fast_key_ff, amp2, early2, fast2, ext_clk_ff;
	logic [2:0] mode_ff, mode2;
	logic [RF_W-1:0] rf_freq_ff, rf2;
	logic [31:0] rnd = 32'h0000E690;
	logic exp_q[$];
	int errors = 0;
	int num_checks = 0;

	always #12.5 clk = ~clk;
	rts_link_if rts_link_if_i ();
	rts_link_if lk ();
	rts_dev #(.LOCK_CYC(LK)) rts_dev_i (.clk(clk), .reset(reset),
		.link(rts_link_if_i), .mode_ff(mode_ff), .osc_on_ff(osc_on_ff),
		.locked_ff(locked_ff), .amp_on_ff(amp_on_ff), .rf_freq_ff(rf_freq_ff),
		.early_key_ff(early_key_ff), .fast_key_ff(fast_key_ff));
	rts_dev #(.LOCK_CYC(LK)) rts_dev_loose_i (.clk(clk), .reset(reset),
		.link(lk), .mode_ff(mode2), .osc_on_ff(), .locked_ff(),
		.amp_on_ff(amp2), .rf_freq_ff(rf2), .early_key_ff(early2),
		.fast_key_ff(fast2));
	rts_host #(.WAIT_CYC(WT)) rts_host_i (.clk(clk), .reset(reset),
		.link(rts_link_if_i), .tx_start(tx_start), .tx_fsk(tx_fsk),
		.tx_bit(tx_bit), .tx_stop(tx_stop), .busy_ff(busy_ff),
		.bit_take_ff(bit_take_ff), .ext_clk_ff(ext_clk_ff));
	rts_link_props #(.WAIT_CYC(WT)) rts_link_props_i (.clk(clk),
		.reset(reset), .chip_en(rts_link_if_i.chip_en),
		.amplifier_on(rts_link_if_i.amplifier_on),
		.cap_sw_out(rts_link_if_i.cap_sw_out),
		.cap_sw_oe(rts_link_if_i.cap_sw_oe),
		.clk_out(rts_link_if_i.clk_out), .cap_line(rts_link_if_i.cap_line));
	// ------------------------------
	// Tasks
	// ------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic conclude();
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cyc
	task automatic next_bit();
		rnd = xs(rnd);
		tx_bit = rnd[0];
		exp_q.push_back(rnd[0]);
	endtask : next_bit
	// Sends n random bits; stop is raised after the last one is taken
	task automatic send(input logic f, input int n);
		int k;
		k = 0;
		fsk = f;
		tx_fsk = f;
		tx_start = 1'b1;
		next_bit();
		cyc(1);
		tx_start = 1'b0;
		cyc(1);
		check("mode", mode_ff, 3'b010);
		check("osc", osc_on_ff, 1'b1);
		while (k < n) begin
			cyc(1);
			if (bit_take_ff === 1'b1) begin
				k++;
				if (k < n)
					next_bit();
			end
		end
		check("locked", locked_ff, 1'b1);
		check("early", early_key_ff, 1'b0);
		check("fast", fast_key_ff, 1'b0);
		check("ext_clk", ext_clk_ff, 1'b1);
		tx_stop = 1'b1;
		cyc(1);
		tx_stop = 1'b0;
		for (k = 0; k < 2000 && busy_ff !== 1'b0; k++)
			cyc(1);
		cyc(2);
		check("standby", mode_ff, 3'b001);
		check("clk_out", rts_link_if_i.clk_out, 1'b0);
		check("amp_off", amp_on_ff, 1'b0);
		check("osc_off", osc_on_ff, 1'b0);
		check("unlocked", locked_ff, 1'b0);
		check("rf_off", rf_freq_ff, {11'h0, RF_OFF});
		check("busy", busy_ff, 1'b0);
		check("own_clk", ext_clk_ff, 1'b0);
	endtask : send
	// Hand-keyed transmitter that breaks the controller's rules on purpose
	task automatic loose();
		lk.chip_en = 1'b1;
		cyc(3);
		lk.amplifier_on = 1'b1;
		cyc(2);
		check("amp2", amp2, 1'b1);
		check("early2", early2, 1'b1);
		lk.chip_en = 1'b0;
		cyc(2);
		check("amp2_off", amp2, 1'b0);
		lk.amplifier_on = 1'b0;
		lk.chip_en = 1'b1;
		cyc(LK + 2);
		check("lock2", mode2, 3'b100);
		lk.cap_sw_oe = 1'b1;
		cyc(2);
		check("rf2", rf2, {11'h0, REF_NOMINAL - REF_PULL, 5'h00});
		lk.amplifier_on = 1'b1;
		cyc(3);
		lk.amplifier_on = 1'b0;
		cyc(2);
		check("fast2", fast2, 1'b1);
		check("late2", early2, 1'b0);
	endtask : loose
	// ------------------------------
	// Monitor and main sequence
	// ------------------------------
	always begin
		@(posedge clk);
		#1;
		if (bit_take_ff === 1'b1 && exp_q.size() > 0) begin
			b = exp_q.pop_front();
			@(posedge clk);
			#1;
			check("amp", amp_on_ff, fsk ? 1'b1 : b);
			check("rf", rf_freq_ff, {11'h0, (fsk && b) ? REF_NOMINAL - REF_PULL
				: REF_NOMINAL, 5'h00});
		end
	end
	initial begin
		lk.chip_en = 1'b0;
		lk.amplifier_on = 1'b0;
		lk.cap_sw_out = 1'b0;
		lk.cap_sw_oe = 1'b0;
		cyc(5);
		reset = 1'b0;
		check("reset", mode_ff, 3'b001);
		send(1'b0, 5);
		send(1'b1, 5);
		loose();
		conclude();
	end
	initial begin
		#(25 * 40000);
		errors++;
		conclude();
	end
endmodule : tb_top
`default_nettype wire
